// ---- pkg/dgp_pkg.sv ----
package dgp_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] DGP_OFS_E_DIR = 8'h00;
    localparam logic [7:0] DGP_OFS_E_PINS = 8'h04;
    localparam logic [7:0] DGP_OFS_E_LAT = 8'h08;
    localparam logic [7:0] DGP_OFS_MEMCTL = 8'h0C;
    localparam logic [7:0] DGP_OFS_PSPCTL = 8'h10;
    localparam logic [7:0] DGP_OFS_F_DIR = 8'h14;
    localparam logic [7:0] DGP_OFS_F_PINS = 8'h18;
    localparam logic [7:0] DGP_OFS_F_LAT = 8'h1C;
    localparam logic [7:0] DGP_OFS_MUX = 8'h20;
    localparam logic [7:0] DGP_OFS_ANALOG = 8'h24;
    localparam logic [7:0] DGP_OFS_CMP = 8'h28;

    // reset values
    localparam logic [7:0] DGP_RST_DIR = 8'hFF;
    localparam logic [7:0] DGP_RST_E_LAT = 8'h00;
    localparam logic [7:0] DGP_RST_F_LAT = 8'h00;
    localparam logic [7:0] DGP_RST_MEMCTL = 8'h00;
    localparam logic [7:0] DGP_RST_PSPCTL = 8'h00;
    localparam logic [7:0] DGP_RST_MUX = 8'h00;
    localparam logic [7:0] DGP_RST_ANALOG = 8'h00;
    localparam logic [7:0] DGP_RST_CMP = 8'h00;

    // implemented bits of the MEMCTL, PSPCTL, MUX and ANALOG registers
    localparam logic [7:0] DGP_MASK_MEMCTL = 8'hB3;
    localparam logic [7:0] DGP_MASK_PSPCTL = 8'h10;
    localparam logic [7:0] DGP_MASK_MUX = 8'h07;
    localparam logic [7:0] DGP_MASK_ANALOG = 8'h3F;

    // field positions
    localparam int DGP_EXT_BUS_DISABLE_BIT = 7;
    localparam int DGP_SLAVE_PORT_ENABLE_BIT = 4;
    localparam int DGP_CAPTURE2_SEL_BIT = 0;
    localparam int DGP_PWM_SEL_BIT = 1;
    localparam int DGP_MUX_CMP_OE_BIT = 0;
    localparam int DGP_MUX_SSP_EN_BIT = 1;
    localparam int DGP_MUX_REF_OE_BIT = 2;

    // field values
    localparam logic [1:0] DGP_MODE_MCU = 2'h0;
    localparam logic [3:0] DGP_ANALOG_ALL_DIGITAL = 4'hF;
    localparam logic [2:0] DGP_CMP_OFF = 3'h7;
    localparam logic [1:0] DGP_RESP_OKAY = 2'h0;
    localparam logic [1:0] DGP_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DGP_IDLE = 2'b00,
        DGP_WRESP = 2'b01,
        DGP_RDATA = 2'b10
    } dgp_state_e;

    typedef struct packed {
        dgp_state_e st;
        logic aw_ok;
        logic w_ok;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic wen;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] e_dir;
        logic [7:0] e_lat;
        logic [7:0] memctl;
        logic [7:0] pspctl;
        logic [7:0] f_dir;
        logic [7:0] f_lat;
        logic [7:0] mux;
        logic [7:0] analog;
        logic [7:0] cmp;
        logic [7:0] e_in;
        logic [7:0] f_in;
        logic [7:0] e_out;
        logic [7:0] e_oe;
        logic [7:0] f_out;
        logic [7:0] f_oe;
        logic [7:0] f_analog;
        logic slv_rd;
        logic slv_wr;
        logic ssp_sel_n;
    } dgp_regs_s;

    localparam dgp_regs_s DGP_RST_STATE = '{
        st: DGP_IDLE,
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        e_dir: DGP_RST_DIR,
        e_lat: DGP_RST_E_LAT,
        memctl: DGP_RST_MEMCTL,
        pspctl: DGP_RST_PSPCTL,
        f_dir: DGP_RST_DIR,
        f_lat: DGP_RST_F_LAT,
        mux: DGP_RST_MUX,
        analog: DGP_RST_ANALOG,
        cmp: DGP_RST_CMP,
        f_analog: 8'h7F,
        ssp_sel_n: 1'b1,
        default: '0
    };

endpackage : dgp_pkg

// ---- core/dgp_port.sv ----
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module dgp_port
    import dgp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [1:0] i_prog_mode,
    input wire logic [7:0] i_config_word_3_high,
    input wire logic [7:0] i_bus_ad_out,
    input wire logic i_bus_ad_oe,
    input wire logic i_capture2_out,
    input wire logic i_capture2_oe,
    input wire logic i_pwm_c_out,
    input wire logic i_pwm_c_en,
    input wire logic i_pwm_b_out,
    input wire logic i_pwm_b_en,
    input wire logic i_comparator_one_output,
    input wire logic i_comparator_two_output,
    input wire logic [7:0] i_pin_e,
    output logic [7:0] o_pin_e_out,
    output logic [7:0] o_pin_e_oe,
    input wire logic [7:0] i_pin_f,
    output logic [7:0] o_pin_f_out,
    output logic [7:0] o_pin_f_oe,
    output logic [7:0] o_pin_e_sample,
    output logic [7:0] o_pin_f_analog,
    output logic o_slave_read_req,
    output logic o_slave_write_req,
    output logic o_ssp_select_n
);

    dgp_regs_s q;
    dgp_regs_s next_q;

    logic bus_own;
    logic slv_act;
    logic cap2_own;
    logic pwm_here;
    logic f_digital;
    logic cmp_on;
    logic [7:0] f_ana;

    // keeps reserved bits at zero on every store
    function automatic logic [7:0] wr8(
        input logic [7:0] old,
        input logic [7:0] d,
        input logic en,
        input logic [7:0] mask
    );
        wr8 = en ? (d & mask) : old;
    endfunction : wr8

    assign bus_own = (i_prog_mode != DGP_MODE_MCU)
        && !q.memctl[DGP_EXT_BUS_DISABLE_BIT];
    assign slv_act = (i_prog_mode == DGP_MODE_MCU)
        && q.pspctl[DGP_SLAVE_PORT_ENABLE_BIT];
    assign cap2_own = (i_prog_mode == DGP_MODE_MCU)
        && !i_config_word_3_high[DGP_CAPTURE2_SEL_BIT];
    assign pwm_here = i_config_word_3_high[DGP_PWM_SEL_BIT];
    assign f_digital = (q.analog[3:0] == DGP_ANALOG_ALL_DIGITAL);
    assign cmp_on = (q.cmp[2:0] != DGP_CMP_OFF);

    // analog-owned pins of the second port read zero
    always_comb begin
        f_ana = 8'h00;
        if (!f_digital) begin
            f_ana[6:0] = 7'h7F;
        end
        if (cmp_on) begin
            f_ana[6:3] = 4'hF;
        end
        if (q.mux[DGP_MUX_REF_OE_BIT]) begin
            f_ana[5] = 1'b1;
        end
    end

    always_comb begin
        logic [7:0] rv;
        logic rhit;
        logic whit;
        rv = 8'h00;
        rhit = 1'b1;
        whit = 1'b1;
        next_q = q;
        next_q.e_in = i_pin_e;
        next_q.f_in = i_pin_f;

        if (i_s_axi_awvalid && q.awready) begin
            next_q.aw_ok = 1'b1;
            next_q.waddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && q.wready) begin
            next_q.w_ok = 1'b1;
            next_q.wdata = i_s_axi_wdata[7:0];
            next_q.wen = i_s_axi_wstrb[0];
        end

        case (i_s_axi_araddr[7:2])
            DGP_OFS_E_DIR[7:2]: rv = q.e_dir;
            DGP_OFS_E_PINS[7:2]: rv = q.e_in;
            DGP_OFS_E_LAT[7:2]: rv = q.e_lat;
            DGP_OFS_MEMCTL[7:2]: rv = q.memctl;
            DGP_OFS_PSPCTL[7:2]: rv = q.pspctl;
            DGP_OFS_F_DIR[7:2]: rv = q.f_dir;
            DGP_OFS_F_PINS[7:2]: rv = q.f_in & ~f_ana;
            DGP_OFS_F_LAT[7:2]: rv = q.f_lat;
            DGP_OFS_MUX[7:2]: rv = q.mux;
            DGP_OFS_ANALOG[7:2]: rv = q.analog;
            DGP_OFS_CMP[7:2]: rv = q.cmp;
            default: rhit = 1'b0;
        endcase

        // a read taken together with a write address goes first
        case (q.st)
            DGP_IDLE: begin
                if (i_s_axi_arvalid && q.arready) begin
                    next_q.rdata = rv;
                    next_q.rresp = rhit ? DGP_RESP_OKAY
                        : DGP_RESP_SLVERR;
                    next_q.rvalid = 1'b1;
                    next_q.st = DGP_RDATA;
                end else if (q.aw_ok && q.w_ok) begin
                    case (q.waddr[7:2])
                        DGP_OFS_E_DIR[7:2]: begin
                            next_q.e_dir = wr8(q.e_dir, q.wdata,
                                q.wen, 8'hFF);
                        end
                        DGP_OFS_E_PINS[7:2], DGP_OFS_E_LAT[7:2]: begin
                            next_q.e_lat = wr8(q.e_lat, q.wdata,
                                q.wen, 8'hFF);
                        end
                        DGP_OFS_MEMCTL[7:2]: begin
                            next_q.memctl = wr8(q.memctl, q.wdata,
                                q.wen, DGP_MASK_MEMCTL);
                        end
                        DGP_OFS_PSPCTL[7:2]: begin
                            next_q.pspctl = wr8(q.pspctl, q.wdata,
                                q.wen, DGP_MASK_PSPCTL);
                        end
                        DGP_OFS_F_DIR[7:2]: begin
                            next_q.f_dir = wr8(q.f_dir, q.wdata,
                                q.wen, 8'hFF);
                        end
                        DGP_OFS_F_PINS[7:2], DGP_OFS_F_LAT[7:2]: begin
                            next_q.f_lat = wr8(q.f_lat, q.wdata,
                                q.wen, 8'hFF);
                        end
                        DGP_OFS_MUX[7:2]: begin
                            next_q.mux = wr8(q.mux, q.wdata,
                                q.wen, DGP_MASK_MUX);
                        end
                        DGP_OFS_ANALOG[7:2]: begin
                            next_q.analog = wr8(q.analog, q.wdata,
                                q.wen, DGP_MASK_ANALOG);
                        end
                        DGP_OFS_CMP[7:2]: begin
                            next_q.cmp = wr8(q.cmp, q.wdata,
                                q.wen, 8'hFF);
                        end
                        default: whit = 1'b0;
                    endcase
                    next_q.aw_ok = 1'b0;
                    next_q.w_ok = 1'b0;
                    next_q.bresp = whit ? DGP_RESP_OKAY
                        : DGP_RESP_SLVERR;
                    next_q.bvalid = 1'b1;
                    next_q.st = DGP_WRESP;
                end
            end
            DGP_WRESP: begin
                if (i_s_axi_bready) begin
                    next_q.bvalid = 1'b0;
                    next_q.st = DGP_IDLE;
                end
            end
            DGP_RDATA: begin
                if (i_s_axi_rready) begin
                    next_q.rvalid = 1'b0;
                    next_q.st = DGP_IDLE;
                end
            end
            default: begin
                next_q.st = DGP_IDLE;
            end
        endcase

        // external bus control is held cleared in microcontroller mode
        if (i_prog_mode == DGP_MODE_MCU) begin
            next_q.memctl = DGP_RST_MEMCTL;
        end

        next_q.awready = (next_q.st == DGP_IDLE) && !next_q.aw_ok;
        next_q.wready = (next_q.st == DGP_IDLE) && !next_q.w_ok;
        next_q.arready = (next_q.st == DGP_IDLE) && !next_q.aw_ok
            && !next_q.w_ok;

        // overrides act on the pin only, the direction register stays
        for (int k = 0; k < 8; k++) begin
            next_q.e_out[k] = q.e_lat[k];
            next_q.e_oe[k] = !q.e_dir[k];
            if (slv_act && k < 3) begin
                next_q.e_oe[k] = 1'b0;
            end
            if (k == 7 && cap2_own) begin
                next_q.e_out[k] = i_capture2_out;
                next_q.e_oe[k] = i_capture2_oe;
            end
            if (k == 5 && pwm_here && i_pwm_c_en) begin
                next_q.e_out[k] = i_pwm_c_out;
                next_q.e_oe[k] = 1'b1;
            end
            if (k == 6 && pwm_here && i_pwm_b_en) begin
                next_q.e_out[k] = i_pwm_b_out;
                next_q.e_oe[k] = 1'b1;
            end
            if (bus_own) begin
                next_q.e_out[k] = i_bus_ad_out[k];
                next_q.e_oe[k] = i_bus_ad_oe;
            end

            next_q.f_out[k] = q.f_lat[k];
            next_q.f_oe[k] = !q.f_dir[k] && !f_ana[k];
            if (k == 1 && cmp_on && q.mux[DGP_MUX_CMP_OE_BIT]) begin
                next_q.f_out[k] = i_comparator_two_output;
                next_q.f_oe[k] = 1'b1;
            end
            if (k == 2 && cmp_on && q.mux[DGP_MUX_CMP_OE_BIT]) begin
                next_q.f_out[k] = i_comparator_one_output;
                next_q.f_oe[k] = 1'b1;
            end
            if (k == 7 && q.mux[DGP_MUX_SSP_EN_BIT]) begin
                next_q.f_oe[k] = 1'b0;
            end
        end
        next_q.f_analog = f_ana;

        // chip select high blocks both strobes
        next_q.slv_rd = slv_act && !q.e_in[2] && !q.e_in[0];
        next_q.slv_wr = slv_act && !q.e_in[2] && !q.e_in[1];
        next_q.ssp_sel_n = q.mux[DGP_MUX_SSP_EN_BIT] ? q.f_in[7]
            : 1'b1;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            q <= DGP_RST_STATE;
        end else begin
            q <= next_q;
        end
    end

    assign o_s_axi_awready = q.awready;
    assign o_s_axi_wready = q.wready;
    assign o_s_axi_bresp = q.bresp;
    assign o_s_axi_bvalid = q.bvalid;
    assign o_s_axi_arready = q.arready;
    assign o_s_axi_rdata = {24'h000000, q.rdata};
    assign o_s_axi_rresp = q.rresp;
    assign o_s_axi_rvalid = q.rvalid;
    assign o_pin_e_out = q.e_out;
    assign o_pin_e_oe = q.e_oe;
    assign o_pin_f_out = q.f_out;
    assign o_pin_f_oe = q.f_oe;
    assign o_pin_e_sample = q.e_in;
    assign o_pin_f_analog = q.f_analog;
    assign o_slave_read_req = q.slv_rd;
    assign o_slave_write_req = q.slv_wr;
    assign o_ssp_select_n = q.ssp_sel_n;

    AST_DIR_INPUT: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (!bus_own && q.e_dir[3]) |=> !o_pin_e_oe[3])
        else $error("input direction still drives pin");
    AST_DIR_OUTPUT: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (!bus_own && !q.e_dir[4] && !(pwm_here && i_pwm_c_en))
        |=> (o_pin_e_oe[4] && o_pin_e_out[4] == $past(q.e_lat[4])))
        else $error("output pin does not follow latch");
    AST_LATCH_READ: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (i_s_axi_arvalid && o_s_axi_arready
            && i_s_axi_araddr == DGP_OFS_E_LAT)
        |=> (o_s_axi_rvalid && o_s_axi_rdata[7:0] == $past(q.e_lat)))
        else $error("latch read does not return latch");
    AST_BUS_OWNS: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        bus_own |=> (o_pin_e_oe == {8{$past(i_bus_ad_oe)}}
            && o_pin_e_out == $past(i_bus_ad_out)))
        else $error("bus mode does not own the port");
    AST_SLAVE_INPUTS: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (slv_act && !bus_own) |=> (o_pin_e_oe[2:0] == 3'h0))
        else $error("slave port control pins driven");
    AST_CAPTURE2: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (cap2_own && !bus_own)
        |=> (o_pin_e_out[7] == $past(i_capture2_out)
            && o_pin_e_oe[7] == $past(i_capture2_oe)))
        else $error("capture two not routed to bit 7");
    AST_CS_BLOCKS: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        q.e_in[2] |=> (!o_slave_read_req && !o_slave_write_req))
        else $error("strobe passed while deselected");
    AST_READ_STROBE: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (slv_act && !q.e_in[2] && !q.e_in[0]) |=> o_slave_read_req)
        else $error("selected read strobe missed");
    AST_ANALOG_ZERO: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (i_s_axi_arvalid && o_s_axi_arready && !f_digital
            && i_s_axi_araddr == DGP_OFS_F_PINS)
        |=> (o_s_axi_rdata[6:0] == 7'h00))
        else $error("analog pins do not read zero");
    AST_DIR_KEPT: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (q.st != DGP_IDLE || !q.aw_ok || !q.w_ok)
        |=> (q.e_dir == $past(q.e_dir)))
        else $error("direction changed without a write");
    AST_CMP_OUT: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (cmp_on && q.mux[DGP_MUX_CMP_OE_BIT])
        |=> (o_pin_f_oe[2:1] == 2'h3 && o_pin_f_out[1]
            == $past(i_comparator_two_output)))
        else $error("comparator output not on pin");

endmodule : dgp_port

`default_nettype wire

// ---- bench/dgp_pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module dgp_pin_partner (
    input wire logic [7:0] i_e_out,
    input wire logic [7:0] i_e_oe,
    input wire logic [7:0] i_f_out,
    input wire logic [7:0] i_f_oe,
    input wire logic [7:0] i_e_ext,
    input wire logic [7:0] i_f_ext,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_cs_n,
    output logic [7:0] o_pin_e,
    output logic [7:0] o_pin_f
);
    logic [7:0] host_e;

    // host strobes idle high: no access while deselected
    always_comb begin
        host_e = {i_e_ext[7:3], i_cs_n, i_wr_n, i_rd_n};
        o_pin_e = (i_e_oe & i_e_out) | (~i_e_oe & host_e);
        o_pin_f = (i_f_oe & i_f_out) | (~i_f_oe & i_f_ext);
    end
endmodule : dgp_pin_partner

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dgp_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] mode = 2'h0;
    logic [7:0] cfg = 8'h01, bus_d = '0;
    logic bus_oe = 1'b0, cap_o = 1'b0, cap_oe = 1'b0;
    logic pc_o = 1'b0, pc_en = 1'b0, pb_o = 1'b0, pb_en = 1'b0;
    logic c1 = 1'b0, c2 = 1'b0, rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1;
    logic [7:0] pin_e, pin_f, e_ext = 8'hFF, f_ext = 8'hFF;
    logic [7:0] pe_out, pe_oe, pf_out, pf_oe, pf_an, e_smp;
    logic slv_rd, slv_wr, ssp_n;
    logic [7:0] dir, lat, v, hv;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    int n_mismatch = 0, num_checks = 0, cyc = 0;

    always #10 clk = ~clk;

    dgp_port dut (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_prog_mode(mode),
        .i_config_word_3_high(cfg), .i_bus_ad_out(bus_d),
        .i_bus_ad_oe(bus_oe), .i_capture2_out(cap_o),
        .i_capture2_oe(cap_oe), .i_pwm_c_out(pc_o), .i_pwm_c_en(pc_en),
        .i_pwm_b_out(pb_o), .i_pwm_b_en(pb_en),
        .i_comparator_one_output(c1), .i_comparator_two_output(c2),
        .i_pin_e(pin_e), .o_pin_e_out(pe_out), .o_pin_e_oe(pe_oe),
        .i_pin_f(pin_f), .o_pin_f_out(pf_out), .o_pin_f_oe(pf_oe),
        .o_pin_e_sample(e_smp), .o_pin_f_analog(pf_an),
        .o_slave_read_req(slv_rd), .o_slave_write_req(slv_wr),
        .o_ssp_select_n(ssp_n));

    dgp_pin_partner far_side (.i_e_out(pe_out), .i_e_oe(pe_oe),
        .i_f_out(pf_out), .i_f_oe(pf_oe), .i_e_ext(e_ext),
        .i_f_ext(f_ext), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cs_n(cs_n),
        .o_pin_e(pin_e), .o_pin_f(pin_f));

    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_bus(input string nm, input logic [33:0] ex,
                           input logic [33:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask : chk_bus

    task automatic chk_pin(input string nm, input logic [7:0] ex,
                           input logic [7:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask : chk_pin

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({er, 32'h0});
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({er, 24'h0, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle

    task automatic do_reset;
        rst_n <= 1'b0;
        settle(10);
        rst_n <= 1'b1;
    endtask : do_reset

    // responses are judged where they appear, in issue order
    always @(posedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            note = exp_q.pop_front();
            if (bvalid && bready) chk_bus("bresp", {note[33:32], 32'h0},
                                          {bresp, 32'h0});
            else chk_bus("rdata", note, {rresp, rdata});
        end
    end

    // whole run needs far fewer cycles; a hang ends here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'hD93EE9D3));
        do_reset();
        rd(DGP_OFS_E_DIR, 8'hFF, DGP_RESP_OKAY);
        rd(DGP_OFS_F_DIR, 8'hFF, DGP_RESP_OKAY);
        rd(DGP_OFS_F_LAT, 8'h00, DGP_RESP_OKAY);
        rd(DGP_OFS_PSPCTL, 8'h00, DGP_RESP_OKAY);
        rd(DGP_OFS_F_PINS, {f_ext[7], 7'h00}, DGP_RESP_OKAY);
        chk_pin("f_oe", 8'h00, pf_oe & 8'h7F);
        rd(8'h3C, 8'h00, DGP_RESP_SLVERR);
        wr(8'h3C, 8'h55, DGP_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            dir = 8'($urandom);
            lat = 8'($urandom);
            e_ext <= 8'($urandom);
            wr(DGP_OFS_E_DIR, dir, DGP_RESP_OKAY);
            wr(i[0] ? DGP_OFS_E_PINS : DGP_OFS_E_LAT, lat,
               DGP_RESP_OKAY);
            settle(3);
            hv = {e_ext[7:3], cs_n, wr_n, rd_n};
            chk_pin("e_oe", ~dir, pe_oe);
            chk_pin("e_out", lat & ~dir, pe_out & ~dir);
            chk_pin("e_smp", (lat & ~dir) | (hv & dir), e_smp);
            rd(DGP_OFS_E_LAT, lat, DGP_RESP_OKAY);
            rd(DGP_OFS_E_PINS, (lat & ~dir) | (hv & dir),
               DGP_RESP_OKAY);
        end
        v = 8'($urandom);
        mode <= 2'h1;
        bus_d <= v;
        bus_oe <= 1'b1;
        settle(3);
        chk_pin("e_out", v, pe_out);
        chk_pin("e_oe", 8'hFF, pe_oe);
        rd(DGP_OFS_E_DIR, dir, DGP_RESP_OKAY);
        wr(DGP_OFS_MEMCTL, 8'h80, DGP_RESP_OKAY);
        settle(3);
        chk_pin("e_oe", ~dir, pe_oe);
        mode <= 2'h0;
        bus_oe <= 1'b0;
        wr(DGP_OFS_E_DIR, 8'hFF, DGP_RESP_OKAY);
        v = 8'($urandom);
        cfg <= 8'h02;
        {cap_o, pb_o, pc_o} <= v[2:0];
        {cap_oe, pb_en, pc_en} <= 3'b111;
        settle(3);
        chk_pin("e_oe", 8'hE0, pe_oe);
        chk_pin("e_hi", {5'h0, v[2:0]}, {5'h0, pe_out[7:5]});
        cfg <= 8'h01;
        settle(3);
        chk_pin("e_oe", 8'h00, pe_oe);
        {cap_oe, pb_en, pc_en} <= 3'b000;
        wr(DGP_OFS_ANALOG, 8'h0F, DGP_RESP_OKAY);
        wr(DGP_OFS_PSPCTL, 8'h10, DGP_RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            cs_n <= k[1];
            rd_n <= k[0];
            wr_n <= ~k[0];
            settle(6);
            chk_pin("slave_req", {6'h0, ~k[1] & k[0], ~k[1] & ~k[0]},
                    {6'h0, slv_wr, slv_rd});
        end
        {cs_n, rd_n, wr_n} <= 3'b111;
        wr(DGP_OFS_CMP, 8'h07, DGP_RESP_OKAY);
        wr(DGP_OFS_F_DIR, 8'h00, DGP_RESP_OKAY);
        v = 8'($urandom);
        wr(DGP_OFS_F_LAT, v, DGP_RESP_OKAY);
        settle(3);
        chk_pin("f_oe", 8'hFF, pf_oe);
        chk_pin("f_out", v, pf_out);
        rd(DGP_OFS_F_LAT, v, DGP_RESP_OKAY);
        wstrb <= 4'h0;
        wr(DGP_OFS_F_LAT, ~v, DGP_RESP_OKAY);
        wstrb <= 4'hF;
        rd(DGP_OFS_F_LAT, v, DGP_RESP_OKAY);
        wr(DGP_OFS_F_DIR, 8'hFF, DGP_RESP_OKAY);
        v = 8'($urandom);
        f_ext <= v;
        settle(3);
        rd(DGP_OFS_F_PINS, v, DGP_RESP_OKAY);
        v = 8'($urandom);
        {c1, c2} <= v[1:0];
        wr(DGP_OFS_CMP, 8'h00, DGP_RESP_OKAY);
        wr(DGP_OFS_MUX, 8'h07, DGP_RESP_OKAY);
        settle(3);
        chk_pin("f_cmp", {6'h0, v[1:0]}, {6'h0, pf_out[2:1]});
        chk_pin("f_cmp_oe", 8'h03, {6'h0, pf_oe[2:1]});
        chk_pin("f_an", 8'h0F, {4'h0, pf_an[6:3]});
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wr(DGP_OFS_MUX, 8'h00, DGP_RESP_OKAY);
            f_ext <= {k[0], 7'h0};
            settle(4);
            chk_pin("ssp_n", {7'h0, k[0] | k[1]}, {7'h0, ssp_n});
        end
        // second reset with the external bus mode selected
        v = 8'($urandom);
        mode <= 2'h1;
        bus_d <= v;
        bus_oe <= 1'b1;
        do_reset();
        settle(3);
        chk_pin("e_out", v, pe_out);
        chk_pin("e_oe", 8'hFF, pe_oe);
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
